// ===== core/sspk_pkg.sv
// shared types and constants of the sweep status byte packer
package sspk_pkg;

  // ***********************************************
  // sizes and timing
  // ***********************************************
  localparam int BYTE_COUNT = 6;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 9;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SETTLE_NS = 16;
  localparam int SETTLE_CYC_RAW = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;
  localparam logic [2:0] LAST_BYTE_IDX = 3'h5;

  // ***********************************************
  // legal code bounds of each encoded field
  // ***********************************************
  localparam logic [2:0] MARKER_MIN = 3'h1;
  localparam logic [2:0] MARKER_MAX = 3'h5;
  localparam logic [2:0] TRIG_MAX = 3'h2;
  localparam logic [2:0] SOURCE_MAX = 3'h5;
  localparam logic [2:0] MODE_MAX = 3'h3;
  localparam logic [2:0] LEVEL_MAX = 3'h2;

  // ***********************************************
  // status byte layouts, msb first
  // ***********************************************
  typedef struct packed {
    logic [1:0] unused;
    logic [2:0] lastMarker;
    logic [2:0] activeMarker;
  } sspk_byte3_t;

  typedef struct packed {
    logic delta;
    logic counted;
    logic [4:0] markerOn;
    logic markerSweep;
  } sspk_byte4_t;

  typedef struct packed {
    logic [2:0] mode;
    logic [2:0] source;
    logic [1:0] trigger;
  } sspk_byte5_t;

  typedef struct packed {
    logic unusedHi;
    logic altSweep;
    logic saveLock;
    logic knobEntry;
    logic squareMod;
    logic rfBlank;
    logic dispBlank;
    logic unusedLo;
  } sspk_byte6_t;

  typedef struct packed {
    logic [1:0] unused;
    logic rfOutput;
    logic rfSlope;
    logic rfPowerSweep;
    logic cwFilter;
    logic [1:0] leveling;
  } sspk_byte7_t;

  typedef struct packed {
    logic [1:0] unused;
    logic ampMod;
    logic freqMod;
    logic pulseMod;
    logic phaseLock;
    logic xtalIntensity;
    logic xtalAmplitude;
  } sspk_byte8_t;

  // byte 3 sits in the low bits so byte k is at index k-3
  typedef struct packed {
    sspk_byte8_t b8;
    sspk_byte7_t b7;
    sspk_byte6_t b6;
    sspk_byte5_t b5;
    sspk_byte4_t b4;
    sspk_byte3_t b3;
  } sspk_snap_t;

  // raw instrument state as held elsewhere
  typedef struct packed {
    logic [2:0] activeMarker;
    logic [2:0] lastMarker;
    logic markerSweep;
    logic [4:0] markerOn;
    logic counted;
    logic delta;
    logic [2:0] trigger;
    logic [2:0] source;
    logic [2:0] mode;
    logic dispBlank;
    logic rfBlank;
    logic squareMod;
    logic knobEntry;
    logic saveLock;
    logic altSweep;
    logic [2:0] leveling;
    logic cwFilter;
    logic rfPowerSweep;
    logic rfSlope;
    logic rfOutput;
    logic xtalAmplitude;
    logic xtalIntensity;
    logic phaseLock;
    logic pulseMod;
    logic freqMod;
    logic ampMod;
  } sspk_inst_t;

  typedef struct packed {
    logic last;
    logic [7:0] data;
  } sspk_word_t;

endpackage

// ===== core/sspk_packer.sv
// status byte packer with its byte fifo and talker handshake
`timescale 1ns/1ps

// ***********************************************
// byte fifo
// ***********************************************
module sspk_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [CW-1:0] count;
  } sspk_fifo_state_t;

  sspk_fifo_state_t s_r;
  sspk_fifo_state_t s_nxt;
  logic doWr;
  logic doRd;

  always_comb begin
    doWr = inValid && (s_r.count != FULL);
    doRd = outReady && (s_r.count != '0);
    s_nxt = s_r;
    if (doWr) begin
      s_nxt.mem[s_r.wrPtr] = inData;
      s_nxt.wrPtr = (s_r.wrPtr == AW'(DEPTH - 1)) ? '0 : s_r.wrPtr + 1'b1;
    end
    if (doRd) begin
      s_nxt.rdPtr = (s_r.rdPtr == AW'(DEPTH - 1)) ? '0 : s_r.rdPtr + 1'b1;
    end
    if (doWr && !doRd) begin
      s_nxt.count = s_r.count + 1'b1;
    end else if (doRd && !doWr) begin
      s_nxt.count = s_r.count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign inReady = (s_r.count != FULL);
  assign outValid = (s_r.count != '0);
  assign outData = s_r.mem[s_r.rdPtr];
endmodule

// ***********************************************
// packer top
// ***********************************************
// Behaviour
// (RULE1) active marker number in byte 3 bits 0-2
// (RULE2) last active marker in byte 3 bits 3-5
// (RULE3) byte 3 and byte 7 bits 6-7 unused
// (RULE4) byte 4 marker sweep, markers, counted, delta
// (RULE5) flag bit one means function active
// (RULE6) byte 5 bits 0-1 sweep trigger code
// (RULE7) byte 5 bits 2-4 sweep source code
// (RULE8) byte 5 bits 5-7 sweep mode code
// (RULE9) byte 6 bits 1-6 panel flags
// (RULE10) byte 7 bits 0-1 leveling mode code
// (RULE11) byte 7 bits 2-5 output flags
// (RULE12) byte 8 bits 0-5 reference and modulation flags
// (RULE13) five markers, marker numbers 1 to 5
// (RULE14) one byte per interlocked three-wire handshake
// (RULE15) unused bits zero, one consistent snapshot
// (RULE16) out-of-range codes replaced by code zero
module sspk_packer (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sendReq,
  input wire sspk_pkg::sspk_inst_t inst,
  input wire logic nrfdIn,
  input wire logic ndacIn,
  output logic [7:0] dioOut,
  output logic dioOe,
  output logic davOut,
  output logic davOe,
  output logic eoiOut,
  output logic eoiOe,
  output logic packBusy
);

  typedef enum logic [1:0] {PK_IDLE, PK_PUSH} sspk_pk_t;
  typedef enum logic [1:0] {TX_IDLE, TX_SETTLE, TX_HOLD, TX_REL} sspk_tx_t;

  typedef struct packed {
    sspk_pk_t pk;
    logic [2:0] idx;
    sspk_pkg::sspk_snap_t snap;
    sspk_tx_t tx;
    logic [3:0] settle;
    logic [7:0] dio;
    logic dioOe;
    logic dav;
    logic eoi;
    logic busy;
  } sspk_state_t;

  sspk_state_t s_r;
  sspk_state_t s_nxt;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoOutReady;
  logic fifoInValid;
  sspk_pkg::sspk_word_t fifoIn;
  sspk_pkg::sspk_word_t fifoOut;
  logic [sspk_pkg::FIFO_WIDTH-1:0] fifoOutRaw;

  // pass a code inside its legal range, else code zero
  function automatic logic [2:0] legalCode(input logic [2:0] v, input logic [2:0] lo, input logic [2:0] hi);
    legalCode = (v >= lo && v <= hi) ? v : 3'h0;
  endfunction

  function automatic sspk_pkg::sspk_snap_t buildSnap(input sspk_pkg::sspk_inst_t st);
    sspk_pkg::sspk_snap_t b;
    b = '0; // [RULE3] [RULE15]
    b.b3.activeMarker = legalCode(st.activeMarker, sspk_pkg::MARKER_MIN, sspk_pkg::MARKER_MAX); // [RULE1] [RULE13]
    b.b3.lastMarker = legalCode(st.lastMarker, sspk_pkg::MARKER_MIN, sspk_pkg::MARKER_MAX); // [RULE2] [RULE13]
    b.b4.markerSweep = st.markerSweep; // [RULE4] [RULE5]
    b.b4.markerOn = st.markerOn; // [RULE4]
    b.b4.counted = st.counted; // [RULE4]
    b.b4.delta = st.delta; // [RULE4]
    b.b5.trigger = 2'(legalCode(st.trigger, 3'h0, sspk_pkg::TRIG_MAX)); // [RULE6] [RULE16]
    b.b5.source = legalCode(st.source, 3'h0, sspk_pkg::SOURCE_MAX); // [RULE7] [RULE16]
    b.b5.mode = legalCode(st.mode, 3'h0, sspk_pkg::MODE_MAX); // [RULE8] [RULE16]
    b.b6.dispBlank = st.dispBlank; // [RULE9]
    b.b6.rfBlank = st.rfBlank; // [RULE9]
    b.b6.squareMod = st.squareMod; // [RULE9]
    b.b6.knobEntry = st.knobEntry; // [RULE9]
    b.b6.saveLock = st.saveLock; // [RULE9]
    b.b6.altSweep = st.altSweep; // [RULE9]
    b.b7.leveling = 2'(legalCode(st.leveling, 3'h0, sspk_pkg::LEVEL_MAX)); // [RULE10] [RULE16]
    b.b7.cwFilter = st.cwFilter; // [RULE11]
    b.b7.rfPowerSweep = st.rfPowerSweep; // [RULE11]
    b.b7.rfSlope = st.rfSlope; // [RULE11]
    b.b7.rfOutput = st.rfOutput; // [RULE11]
    b.b8.xtalAmplitude = st.xtalAmplitude; // [RULE12]
    b.b8.xtalIntensity = st.xtalIntensity; // [RULE12]
    b.b8.phaseLock = st.phaseLock; // [RULE12]
    b.b8.pulseMod = st.pulseMod; // [RULE12]
    b.b8.freqMod = st.freqMod; // [RULE12]
    b.b8.ampMod = st.ampMod; // [RULE12]
    buildSnap = b;
  endfunction

  // ***********************************************
  // snapshot and push
  // ***********************************************
  // byte selection straight off the frozen copy, so a state change mid-send
  // cannot tear the sequence
  always_comb begin
    fifoInValid = (s_r.pk == PK_PUSH);
    fifoIn.data = s_r.snap[{s_r.idx, 3'h0} +: 8]; // [RULE15]
    fifoIn.last = (s_r.idx == sspk_pkg::LAST_BYTE_IDX);
    fifoOutReady = (s_r.tx == TX_IDLE);
    fifoOut = sspk_pkg::sspk_word_t'(fifoOutRaw);
    s_nxt = s_r;
    case (s_r.pk)
      PK_IDLE: begin
        if (sendReq) begin
          s_nxt.snap = buildSnap(inst); // [RULE15]
          s_nxt.idx = 3'h0;
          s_nxt.pk = PK_PUSH;
          s_nxt.busy = 1'b1;
        end
      end
      PK_PUSH: begin
        if (fifoInReady) begin
          if (s_r.idx == sspk_pkg::LAST_BYTE_IDX) begin
            s_nxt.pk = PK_IDLE;
            s_nxt.busy = 1'b0;
          end else begin
            s_nxt.idx = s_r.idx + 3'h1;
          end
        end
      end
      default: begin
        s_nxt.pk = PK_IDLE;
      end
    endcase

    // ***********************************************
    // talker handshake
    // ***********************************************
    case (s_r.tx)
      TX_IDLE: begin
        if (fifoOutValid) begin
          s_nxt.dio = fifoOut.data;
          s_nxt.eoi = fifoOut.last;
          s_nxt.dioOe = 1'b1;
          s_nxt.settle = 4'(sspk_pkg::SETTLE_CYC);
          s_nxt.tx = TX_SETTLE;
        end
      end
      TX_SETTLE: begin
        // data must settle before valid; wait for every listener ready
        if (s_r.settle != 4'h0) begin
          s_nxt.settle = s_r.settle - 4'h1;
        end else if (!nrfdIn) begin
          s_nxt.dav = 1'b1; // [RULE14]
          s_nxt.tx = TX_HOLD;
        end
      end
      TX_HOLD: begin
        if (!ndacIn) begin
          s_nxt.dav = 1'b0; // [RULE14]
          s_nxt.tx = TX_REL;
        end
      end
      TX_REL: begin
        // slowest listener paces us: wait for accepted to drop back
        if (ndacIn) begin
          s_nxt.dioOe = 1'b0;
          s_nxt.eoi = 1'b0;
          s_nxt.tx = TX_IDLE; // [RULE14]
        end
      end
      default: begin
        s_nxt.tx = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  sspk_fifo #(
    .WIDTH(sspk_pkg::FIFO_WIDTH),
    .DEPTH(sspk_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(fifoIn),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutRaw)
  );

  assign dioOut = s_r.dio;
  assign dioOe = s_r.dioOe;
  assign davOut = s_r.dav;
  assign davOe = s_r.dioOe;
  assign eoiOut = s_r.eoi;
  assign eoiOe = s_r.dioOe;
  assign packBusy = s_r.busy;

  // ***********************************************
  // checks
  // ***********************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  wire capture = (s_r.pk == PK_IDLE) && sendReq;

  active_marker_a: assert property (capture |=> // [RULE1] [RULE13]
    s_r.snap.b3.activeMarker == (($past(inst.activeMarker) >= 3'h1 && $past(inst.activeMarker) <= 3'h5)
      ? $past(inst.activeMarker) : 3'h0))
    else $error("active marker field wrong");
  last_marker_a: assert property (capture |=> // [RULE2]
    s_r.snap.b3.lastMarker == (($past(inst.lastMarker) >= 3'h1 && $past(inst.lastMarker) <= 3'h5)
      ? $past(inst.lastMarker) : 3'h0))
    else $error("last marker field wrong");
  unused_bits_a: assert property (s_r.snap.b3.unused == 2'h0 && s_r.snap.b7.unused == 2'h0 // [RULE3] [RULE15]
    && !s_r.snap.b6.unusedLo && !s_r.snap.b6.unusedHi && s_r.snap.b8.unused == 2'h0)
    else $error("unused status bit set");
  marker_flags_a: assert property (capture |=> s_r.snap.b4 == {$past(inst.delta), $past(inst.counted), // [RULE4] [RULE5]
    $past(inst.markerOn), $past(inst.markerSweep)})
    else $error("marker flag byte wrong");
  code_range_a: assert property (s_r.snap.b5.trigger != 2'h3 && s_r.snap.b5.source <= 3'h5 // [RULE16] [RULE6]
    && s_r.snap.b5.mode <= 3'h3 && s_r.snap.b7.leveling != 2'h3)
    else $error("illegal field code");
  panel_flags_a: assert property (capture |=> s_r.snap.b6[6:1] == {$past(inst.altSweep), $past(inst.saveLock), // [RULE9]
    $past(inst.knobEntry), $past(inst.squareMod), $past(inst.rfBlank), $past(inst.dispBlank)})
    else $error("panel flag byte wrong");
  mod_flags_a: assert property (capture |=> s_r.snap.b8[5:0] == {$past(inst.ampMod), $past(inst.freqMod), // [RULE12]
    $past(inst.pulseMod), $past(inst.phaseLock), $past(inst.xtalIntensity), $past(inst.xtalAmplitude)})
    else $error("modulation flag byte wrong");
  dav_hold_a: assert property (davOut && ndacIn |=> davOut && $stable(dioOut)) // [RULE14]
    else $error("valid dropped before acceptance");
  dav_ready_a: assert property ($rose(davOut) |-> $past(!nrfdIn) && dioOe) // [RULE14]
    else $error("valid raised while not ready");
endmodule

// ===== tb/sspk_listener.sv
// bus listener model that accepts status bytes at an adjustable pace
`timescale 1ns/1ps
module sspk_listener (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic stall,
  input wire logic [3:0] delayCyc,
  input wire logic [7:0] dioOut,
  input wire logic dioOe,
  input wire logic davOut,
  input wire logic eoiOut,
  output logic nrfdIn,
  output logic ndacIn,
  output logic rxStrobe,
  output logic [8:0] rxWord
);
  logic nrfd_r = 1'b1;
  logic ndac_r = 1'b1;
  logic strobe_r = 1'b0;
  logic [8:0] word_r = 9'h000;
  logic [3:0] cnt_r = 4'h0;
  logic [1:0] st_r = 2'h0;
  assign nrfdIn = nrfd_r;
  assign ndacIn = ndac_r;
  assign rxStrobe = strobe_r;
  assign rxWord = word_r;
  // stall only holds off readiness, never withdraws it once given
  always @(posedge clk) begin
    strobe_r <= 1'b0;
    if (sys_rst) begin
      nrfd_r <= 1'b1;
      ndac_r <= 1'b1;
      cnt_r <= 4'h0;
      st_r <= 2'h0;
    end else begin
      case (st_r)
        2'h0: if (stall) begin
          cnt_r <= 4'h0;
        end else if (cnt_r >= delayCyc) begin
          nrfd_r <= 1'b0;
          st_r <= 2'h1;
        end else begin
          cnt_r <= cnt_r + 4'h1;
        end
        2'h1: if (dioOe && davOut) begin
          nrfd_r <= 1'b1;
          word_r <= {eoiOut, dioOut};
          strobe_r <= 1'b1;
          cnt_r <= 4'h0;
          st_r <= 2'h2;
        end
        2'h2: if (cnt_r >= delayCyc) begin
          ndac_r <= 1'b0;
          st_r <= 2'h3;
        end else begin
          cnt_r <= cnt_r + 4'h1;
        end
        default: if (!davOut) begin
          ndac_r <= 1'b1;
          cnt_r <= 4'h0;
          st_r <= 2'h0;
        end
      endcase
    end
  end
endmodule

// ===== tb/tb.sv
// self-checking bench of the status byte packer
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sendReq = 1'b0;
  sspk_pkg::sspk_inst_t inst = '0;
  logic stall = 1'b0;
  logic [3:0] delayCyc = 4'h0;
  logic nrfdIn, ndacIn, dioOe, davOut, davOe, eoiOut, eoiOe, packBusy, rxStrobe;
  logic [7:0] dioOut;
  logic [8:0] rxWord;
  logic davPrev = 1'b0;
  logic nrfdPrev = 1'b1;
  logic [8:0] expQ[$];
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;

  always #4 clk = ~clk;

  sspk_packer i_sspk_packer (.clk(clk), .sys_rst(sys_rst), .sendReq(sendReq), .inst(inst),
    .nrfdIn(nrfdIn), .ndacIn(ndacIn), .dioOut(dioOut), .dioOe(dioOe), .davOut(davOut),
    .davOe(davOe), .eoiOut(eoiOut), .eoiOe(eoiOe), .packBusy(packBusy));
  sspk_listener i_sspk_listener (.clk(clk), .sys_rst(sys_rst), .stall(stall), .delayCyc(delayCyc),
    .dioOut(dioOut), .dioOe(dioOe), .davOut(davOut), .eoiOut(eoiOut), .nrfdIn(nrfdIn),
    .ndacIn(ndacIn), .rxStrobe(rxStrobe), .rxWord(rxWord));

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  function automatic logic [7:0] expByte(input sspk_pkg::sspk_inst_t s, input int n);
    logic [2:0] am;
    logic [2:0] lm;
    am = (s.activeMarker >= 3'h1 && s.activeMarker <= 3'h5) ? s.activeMarker : 3'h0;
    lm = (s.lastMarker >= 3'h1 && s.lastMarker <= 3'h5) ? s.lastMarker : 3'h0;
    case (n)
      0: expByte = {2'h0, lm, am};
      1: expByte = {s.delta, s.counted, s.markerOn, s.markerSweep};
      2: expByte = {(s.mode <= 3'h3) ? s.mode : 3'h0, (s.source <= 3'h5) ? s.source : 3'h0,
        (s.trigger <= 3'h2) ? s.trigger[1:0] : 2'h0};
      3: expByte = {1'h0, s.altSweep, s.saveLock, s.knobEntry, s.squareMod, s.rfBlank, s.dispBlank,
        1'h0};
      4: expByte = {2'h0, s.rfOutput, s.rfSlope, s.rfPowerSweep, s.cwFilter,
        (s.leveling <= 3'h2) ? s.leveling[1:0] : 2'h0};
      default: expByte = {2'h0, s.ampMod, s.freqMod, s.pulseMod, s.phaseLock, s.xtalIntensity,
        s.xtalAmplitude};
    endcase
  endfunction

  function automatic sspk_pkg::sspk_inst_t mkInst(input logic [2:0] k, input logic [23:0] f);
    mkInst = {k, 3'h7 - k, f[0], f[5:1], f[6], f[7], k, k, k, f[13:8], k, f[17:14], f[23:18]};
  endfunction

  // inst is scrambled after the taking edge so a late sample shows
  task automatic send(input sspk_pkg::sspk_inst_t s, input int hold);
    while (packBusy !== 1'b0) begin
      @(posedge clk);
      #1;
    end
    sendReq = 1'b1;
    inst = s;
    for (int i = 0; i < 6; i++) expQ.push_back({i == 5, expByte(s, i)});
    repeat (hold) @(posedge clk);
    #1;
    sendReq = 1'b0;
    inst = ~s;
  endtask

  task automatic waitDrain(input string name);
    while (expQ.size() != 0) @(posedge clk);
    repeat (8) @(posedge clk);
    #1;
    $display("test %s done", name);
  endtask

  // ****************************************
  // monitors
  // ****************************************
  always @(posedge clk) begin
    if (davOut && !davPrev) check({8'h0, nrfdPrev}, 9'h0);
    if (davOut && !davPrev) check({6'h0, dioOe, davOe, eoiOe}, 9'h007);
    davPrev <= davOut;
    nrfdPrev <= nrfdIn;
    if (rxStrobe) begin
      if (expQ.size() == 0) begin
        errors++;
        $display("Error at %0t: unexpected byte %h", $time, rxWord);
      end else begin
        check(rxWord, expQ.pop_front());
      end
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("Error at %0t: timeout", $time);
      tally_and_finish();
    end
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (10) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    check({dioOe, davOut, davOe, eoiOut, eoiOe, packBusy, 3'h0}, 9'h0);
    $display("test reset done");
    for (int k = 0; k < 8; k++) send(mkInst(k[2:0], k[0] ? 24'hAAAAAA : 24'h555555), 1);
    waitDrain("codes");
    // request held high for several edges is taken once
    delayCyc = 4'h3;
    send(mkInst(3'h3, 24'hFFFFFF), 4);
    waitDrain("held request");
    // four blocks outgrow the fifo while the listener stalls
    // stall only after readiness is given, so exactly one byte leaves first
    while (nrfdIn !== 1'b0) begin
      @(posedge clk);
      #1;
    end
    stall = 1'b1;
    send(mkInst(3'h1, 24'h000000), 1);
    send(mkInst(3'h2, 24'h123456), 1);
    send(mkInst(3'h5, 24'hFEDCBA), 1);
    send(mkInst(3'h4, 24'h0F0F0F), 1);
    repeat (20) @(posedge clk);
    #1;
    check({8'h0, packBusy}, 9'h1);
    check({8'h0, davOut}, 9'h0);
    stall = 1'b0;
    waitDrain("fifo full");
    tally_and_finish();
  end
endmodule
